/* File: swic_dev_model.sv */
// Device controller and table memory model for the interrupt control block
`timescale 1ns/100ps
module swic_dev_model (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        raise,
  input  wire logic [1:0]  level,
  input  wire logic [9:0]  device,
  input  wire logic [31:0] entry,
  input  wire logic [2:0]  delay,
  output logic             extReq,
  output logic [1:0]       extLevel,
  output logic [9:0]       extDevice,
  input  wire logic        extAck,
  input  wire logic        memReq,
  output logic             memAck,
  output logic [31:0]      memData
);
  logic [9:0] dev_q;
  logic [1:0] lvl_q;
  logic [2:0] cnt_q;
  // Lines not in use show the inverse so stale values never look valid
  assign extDevice = extReq ? dev_q : ~dev_q;
  assign extLevel  = extReq ? lvl_q : ~lvl_q;
  assign memData   = memAck ? entry : ~entry;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      extReq <= 1'b0;
      dev_q  <= 10'h000;
      lvl_q  <= 2'h0;
      cnt_q  <= 3'h0;
      memAck <= 1'b0;
    end else begin
      if (raise) begin
        extReq <= 1'b1;
        dev_q  <= device;
        lvl_q  <= level;
      end else if (extAck) begin
        extReq <= 1'b0;
      end
      memAck <= 1'b0;
      // Delay input lets the memory answer promptly or slowly
      if (memReq && !memAck) begin
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q >= delay) begin
          memAck <= 1'b1;
          cnt_q  <= 3'h0;
        end
      end
    end
  end
endmodule

/* File: swic_level_gate.sv */
// External interrupt level gating from the two level mask bits
`timescale 1ns/100ps
module swic_level_gate (
  input  wire logic       gateA,
  input  wire logic       gateB,
  input  wire logic [1:0] curLevel,
  input  wire logic [1:0] reqLevel,
  output logic            enabled
);
  // Level 0 is the highest priority
  wire higher   = reqLevel < curLevel;
  wire orHigher = reqLevel <= curLevel;
  assign enabled = (!gateA && gateB && higher)
                 || (gateA && !gateB)
                 || (gateA && gateB && orHigher);
endmodule

/* File: swic_mal_queue.sv */
// One-entry pending queue for machine malfunction events and their cause code
`timescale 1ns/100ps
module swic_mal_queue (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       evt,
  input  wire logic [3:0] evtCode,
  input  wire logic       take,
  output logic            pending,
  output logic [3:0]      code
);
  logic       pendQ;
  logic [3:0] codeQ;
  // A new event in the cycle of a take is kept, not lost
  wire        pendD = evt || (pendQ && !take);
  wire [3:0]  codeD = (evt && (!pendQ || take)) ? evtCode : codeQ;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pendQ <= 1'b0;
      codeQ <= 4'h0;
    end else begin
      pendQ <= pendD;
      codeQ <= codeD;
    end
  end
  assign pending = pendQ;
  assign code    = codeQ;
endmodule

/* File: swic_pkg.sv */
// Constants, field positions and register map of the status word and interrupt control
package swic_pkg;
  // Status word bit numbers, bit 0 is the most significant
  localparam int PSW_W        = 64;
  localparam int BIT_WAIT     = 16;
  localparam int BIT_EXT_A    = 17;
  localparam int BIT_MAL      = 18;
  localparam int BIT_ARITH    = 19;
  localparam int BIT_EXT_B    = 20;
  localparam int RS_LO        = 24;
  localparam int RS_LEVEL_LO  = 26;
  localparam int RS_HI        = 27;
  localparam int CC_LO        = 28;
  localparam int CC_HI        = 31;
  localparam int LOC_LO       = 40;
  localparam int LOC_HI       = 63;
  localparam int LOC_W        = 24;
  localparam int DEV_W        = 10;
  localparam logic [63:0] PSW_WR_MASK = 64'h0000ffff_00ffffff;
  localparam logic [63:0] PSW_RST     = 64'h0000000_000000000;
  // Register byte offsets
  localparam logic [11:0] OFF_PSW_HI    = 12'h000;
  localparam logic [11:0] OFF_PSW_LO    = 12'h004;
  localparam logic [11:0] OFF_CTRL      = 12'h008;
  localparam logic [11:0] OFF_STAT      = 12'h00c;
  localparam logic [11:0] OFF_MASK      = 12'h010;
  localparam logic [11:0] OFF_STATE     = 12'h014;
  localparam logic [11:0] OFF_OLD_HI    = 12'h018;
  localparam logic [11:0] OFF_OLD_LO    = 12'h01c;
  localparam logic [11:0] OFF_NEW_EXT   = 12'h020;
  localparam logic [11:0] OFF_NEW_MAL   = 12'h024;
  localparam logic [11:0] OFF_NEW_ARITH = 12'h028;
  localparam logic [11:0] OFF_LOC_MAL   = 12'h02c;
  localparam logic [11:0] OFF_LOC_ARITH = 12'h030;
  localparam logic [11:0] OFF_TABLE     = 12'h034;
  // Control register bits
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_STEP = 2;
  // Event bits in status and mask registers
  localparam int EV_EXT   = 0;
  localparam int EV_MAL   = 1;
  localparam int EV_ARITH = 2;
  localparam int EV_ADC   = 3;
  localparam int EV_W     = 4;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [23:0] LOC_RST  = 24'h00_0000;
  typedef enum logic [0:0] {DISP_IDLE = 1'b0, DISP_FETCH = 1'b1} swic_disp_t;
endpackage

/* File: swic_status_ctrl.sv */
// Status word, interrupt dispatch and run/stop control with APB register access
`timescale 1ns/100ps
// Operation
// - A 64-bit status word with flags, masks and counter governs everything.
// - Status bit 16 holds execution in wait until an interrupt is taken.
// - Taking an interrupt saves the status word and loads a new one.
// - Bits 17 and 20 gate the four external interrupt levels.
// - Current level comes from bits 26 and 27 of the register-set field, bits 24 to 27.
// - Up to 1024 vectored sources across four priority levels.
// - External interrupt reads a table entry addressed by device number.
// - An even entry becomes the new location counter.
// - An odd entry starts the auto driver channel with it as pointer.
// - Bit 18 masks malfunction; masked events stay pending until enabled.
// - Malfunction cause is reported in condition code bits 28 to 31.
// - Bit 19 enables the arithmetic fault interrupt.
// - Stop and run modes; in stop the console alters state and steps.
module swic_status_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        extReq,
  input  wire logic [1:0]  extLevel,
  input  wire logic [9:0]  extDevice,
  output logic             extAck,
  input  wire logic        malEvent,
  input  wire logic [3:0]  malCode,
  input  wire logic        arithFault,
  output logic             memReq,
  output logic [23:0]      memAddr,
  input  wire logic        memAck,
  input  wire logic [31:0] memData,
  output logic             adcStart,
  output logic [23:0]      adcCcbPtr,
  input  wire logic        seqLocValid,
  input  wire logic [23:0] seqLoc,
  output logic             execEnable,
  output logic             execStep,
  output logic [63:0]      pswOut
);
  logic [0:63]              pswQ, pswD, oldPswQ;
  logic [31:0]              newExtQ, newMalQ, newArithQ, prdataQ, rdMux;
  logic [23:0]              locMalQ, locArithQ, tableQ, memAddrQ, adcPtrQ;
  logic [swic_pkg::EV_W-1:0] statQ, statD, maskQ, maskD, evts, rdClr;
  logic                     runQ, runD, preadyQ, errQ, irqQ, extAckQ, memReqQ;
  logic                     adcQ, execEnQ, stepQ, malPending, extEnabled;
  logic [3:0]               malQCode;
  swic_pkg::swic_disp_t     stateQ, stateD;

  // APB decode; the answer comes one cycle into the access phase
  wire apbAcc  = psel && penable && !preadyQ;
  wire apbDone = psel && penable && preadyQ;
  wire wrDone  = apbDone && pwrite && !errQ;
  wire hitPswH = paddr == swic_pkg::OFF_PSW_HI;
  wire hitPswL = paddr == swic_pkg::OFF_PSW_LO;
  wire hitCtrl = paddr == swic_pkg::OFF_CTRL;
  wire hitStat = paddr == swic_pkg::OFF_STAT;
  wire hitMask = paddr == swic_pkg::OFF_MASK;
  wire hitNewE = paddr == swic_pkg::OFF_NEW_EXT;
  wire hitNewM = paddr == swic_pkg::OFF_NEW_MAL;
  wire hitNewA = paddr == swic_pkg::OFF_NEW_ARITH;
  wire hitLocM = paddr == swic_pkg::OFF_LOC_MAL;
  wire hitLocA = paddr == swic_pkg::OFF_LOC_ARITH;
  wire hitTbl  = paddr == swic_pkg::OFF_TABLE;
  wire hitRo   = paddr == swic_pkg::OFF_STATE || paddr == swic_pkg::OFF_OLD_HI
              || paddr == swic_pkg::OFF_OLD_LO;
  wire hitAny  = hitPswH || hitPswL || hitCtrl || hitStat || hitMask || hitNewE
              || hitNewM || hitNewA || hitLocM || hitLocA || hitTbl || hitRo;
  // The console may alter the status word only while stopped
  wire pswWrBad = pwrite && (hitPswH || hitPswL) && runQ;
  wire wrRoBad  = pwrite && (hitRo || hitStat);
  wire errNow   = !hitAny || pswWrBad || wrRoBad;

  // Bits 5:4 of the state word are spare and read as zero
  wire [31:0] stateWord = {22'h0, malPending, stateQ, pswQ[swic_pkg::BIT_WAIT],
                           runQ, 2'h0, pswQ[swic_pkg::RS_LO:swic_pkg::RS_HI]};
  assign rdMux = hitPswH ? pswQ[0:31] :
                 hitPswL ? pswQ[32:63] :
                 hitCtrl ? {31'h0, runQ} :
                 hitStat ? {28'h0, statQ} :
                 hitMask ? {28'h0, maskQ} :
                 paddr == swic_pkg::OFF_STATE  ? stateWord :
                 paddr == swic_pkg::OFF_OLD_HI ? oldPswQ[0:31] :
                 paddr == swic_pkg::OFF_OLD_LO ? oldPswQ[32:63] :
                 hitNewE ? newExtQ :
                 hitNewM ? newMalQ :
                 hitNewA ? newArithQ :
                 hitLocM ? {8'h0, locMalQ} :
                 hitLocA ? {8'h0, locArithQ} :
                 hitTbl  ? {8'h0, tableQ} : swic_pkg::WORD_RST;

  // Interrupt selection; malfunction first, then arithmetic, then external
  wire idle       = stateQ == swic_pkg::DISP_IDLE;
  wire canTake    = runQ && idle;
  wire takeMal    = canTake && malPending && pswQ[swic_pkg::BIT_MAL];
  wire takeArith  = canTake && !takeMal && arithFault
                 && pswQ[swic_pkg::BIT_ARITH];
  wire takeExt    = canTake && !takeMal && !takeArith && extReq && extEnabled;
  wire takeAny    = takeMal || takeArith || takeExt;
  wire fetchDone  = stateQ == swic_pkg::DISP_FETCH && memAck;
  wire entryOdd   = memData[0];
  // Word-sized table entries, so the device number is scaled by four
  wire [23:0] tblAddr = tableQ + {12'h0, extDevice, 2'b00};

  swic_level_gate u_gate (
    .gateA    (pswQ[swic_pkg::BIT_EXT_A]),
    .gateB    (pswQ[swic_pkg::BIT_EXT_B]),
    .curLevel (pswQ[swic_pkg::RS_LEVEL_LO:swic_pkg::RS_HI]),
    .reqLevel (extLevel),
    .enabled  (extEnabled)
  );

  swic_mal_queue u_malq (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .evt     (malEvent),
    .evtCode (malCode),
    .take    (takeMal),
    .pending (malPending),
    .code    (malQCode)
  );

  // Next status word; reserved bits are forced to zero on every load
  always_comb begin
    pswD = pswQ;
    if (wrDone && hitPswH) begin
      pswD[0:31] = pwdata;
    end else if (wrDone && hitPswL) begin
      pswD[32:63] = pwdata;
    end else if (takeMal) begin
      pswD[0:31] = newMalQ;
      pswD[swic_pkg::CC_LO:swic_pkg::CC_HI] = malQCode;
      pswD[swic_pkg::LOC_LO:swic_pkg::LOC_HI] = locMalQ;
    end else if (takeArith) begin
      pswD[0:31] = newArithQ;
      pswD[swic_pkg::LOC_LO:swic_pkg::LOC_HI] = locArithQ;
    end else if (takeExt) begin
      pswD[0:31] = newExtQ;
      pswD[swic_pkg::RS_LEVEL_LO:swic_pkg::RS_HI] = extLevel;
    end else if (fetchDone && !entryOdd) begin
      pswD[swic_pkg::LOC_LO:swic_pkg::LOC_HI] = memData[23:0];
    end else if (seqLocValid && execEnQ) begin
      pswD[swic_pkg::LOC_LO:swic_pkg::LOC_HI] = seqLoc;
    end
    pswD = pswD & swic_pkg::PSW_WR_MASK;
  end

  always_comb begin
    unique case (stateQ)
      swic_pkg::DISP_IDLE:  stateD = takeExt ? swic_pkg::DISP_FETCH : swic_pkg::DISP_IDLE;
      swic_pkg::DISP_FETCH: stateD = memAck ? swic_pkg::DISP_IDLE : swic_pkg::DISP_FETCH;
    endcase
  end

  // Run/stop from the console control register
  assign runD = (wrDone && hitCtrl) ? (pwdata[swic_pkg::CTRL_RUN] ? 1'b1 :
                pwdata[swic_pkg::CTRL_STOP] ? 1'b0 : runQ) : runQ;
  wire stepNow = wrDone && hitCtrl && !runQ && pwdata[swic_pkg::CTRL_STEP]
              && !pswQ[swic_pkg::BIT_WAIT];

  // Sticky events; only bits returned by the read are cleared, so a set wins
  assign evts  = {fetchDone && entryOdd, takeArith, takeMal, takeExt};
  assign rdClr = (apbDone && !pwrite && hitStat) ? prdataQ[3:0] : 4'h0;
  assign statD = (statQ & ~rdClr) | evts;
  assign maskD = (wrDone && hitMask) ? pwdata[3:0] : maskQ;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pswQ      <= swic_pkg::PSW_RST;
      oldPswQ   <= swic_pkg::PSW_RST;
      stateQ    <= swic_pkg::DISP_IDLE;
      runQ      <= 1'b0;
      statQ     <= 4'h0;
      maskQ     <= 4'h0;
      irqQ      <= 1'b0;
      execEnQ   <= 1'b0;
      stepQ     <= 1'b0;
    end else begin
      pswQ      <= pswD;
      if (takeAny) oldPswQ <= pswQ;
      stateQ    <= stateD;
      runQ      <= runD;
      statQ     <= statD;
      maskQ     <= maskD;
      irqQ      <= |(statD & maskD);
      // Wait and dispatch both hold the sequencer off
      execEnQ   <= runD && !pswD[swic_pkg::BIT_WAIT]
                && stateD == swic_pkg::DISP_IDLE;
      stepQ     <= stepNow;
    end
  end

  // Configuration registers and the table fetch handshake
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      newExtQ   <= swic_pkg::WORD_RST;
      newMalQ   <= swic_pkg::WORD_RST;
      newArithQ <= swic_pkg::WORD_RST;
      locMalQ   <= swic_pkg::LOC_RST;
      locArithQ <= swic_pkg::LOC_RST;
      tableQ    <= swic_pkg::LOC_RST;
      memReqQ   <= 1'b0;
      memAddrQ  <= swic_pkg::LOC_RST;
      extAckQ   <= 1'b0;
      adcQ      <= 1'b0;
      adcPtrQ   <= swic_pkg::LOC_RST;
    end else begin
      if (wrDone && hitNewE) newExtQ <= pwdata;
      if (wrDone && hitNewM) newMalQ <= pwdata;
      if (wrDone && hitNewA) newArithQ <= pwdata;
      if (wrDone && hitLocM) locMalQ <= pwdata[23:0];
      if (wrDone && hitLocA) locArithQ <= pwdata[23:0];
      if (wrDone && hitTbl) tableQ <= pwdata[23:0];
      extAckQ <= takeExt;
      if (takeExt) memAddrQ <= tblAddr;
      memReqQ <= takeExt || (memReqQ && !memAck);
      adcQ    <= fetchDone && entryOdd;
      if (fetchDone && entryOdd) adcPtrQ <= memData[23:0];
    end
  end

  // APB answer registers; the error flag stands only in the pready cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      preadyQ <= 1'b0;
      errQ    <= 1'b0;
      prdataQ <= swic_pkg::WORD_RST;
    end else begin
      preadyQ <= apbAcc;
      errQ    <= apbAcc && errNow;
      if (apbAcc) prdataQ <= pwrite ? swic_pkg::WORD_RST : rdMux;
    end
  end

  assign prdata     = prdataQ;
  assign pready     = preadyQ;
  assign pslverr    = errQ;
  assign irq        = irqQ;
  assign extAck     = extAckQ;
  assign memReq     = memReqQ;
  assign memAddr    = memAddrQ;
  assign adcStart   = adcQ;
  assign adcCcbPtr  = adcPtrQ;
  assign execEnable = execEnQ;
  assign execStep   = stepQ;
  assign pswOut     = pswQ;

  a_wait_blocks_exec: assert property (@(posedge ref_clk) disable iff (!nrst)
    pswQ[swic_pkg::BIT_WAIT] |-> !execEnable)
    else $error("executing in wait state");
  a_take_saves_psw: assert property (@(posedge ref_clk) disable iff (!nrst)
    takeAny |=> oldPswQ == $past(pswQ))
    else $error("old status word not saved");
  a_gate_all_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!pswQ[swic_pkg::BIT_EXT_A] && !pswQ[swic_pkg::BIT_EXT_B]) |-> !takeExt)
    else $error("external interrupt taken while all levels disabled");
  a_gate_current: assert property (@(posedge ref_clk) disable iff (!nrst)
    (canTake && extReq && pswQ[swic_pkg::BIT_EXT_A] && pswQ[swic_pkg::BIT_EXT_B]
     && extLevel == pswQ[swic_pkg::RS_LEVEL_LO:swic_pkg::RS_HI] && !malPending
     && !arithFault) |-> takeExt)
    else $error("current level not enabled");
  a_level_to_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    takeExt |=> pswQ[swic_pkg::RS_LEVEL_LO:swic_pkg::RS_HI] == $past(extLevel))
    else $error("register set does not follow level");
  a_table_fetch: assert property (@(posedge ref_clk) disable iff (!nrst)
    takeExt |=> memReq && memAddr == $past(tblAddr))
    else $error("wrong table fetch");
  a_even_entry: assert property (@(posedge ref_clk) disable iff (!nrst)
    (fetchDone && !entryOdd) |=> pswQ[swic_pkg::LOC_LO:swic_pkg::LOC_HI]
      == $past(memData[23:0]) && !adcStart)
    else $error("even entry not loaded as counter");
  a_odd_entry: assert property (@(posedge ref_clk) disable iff (!nrst)
    (fetchDone && entryOdd) |=> adcStart && adcCcbPtr == $past(memData[23:0]))
    else $error("odd entry did not start channel");
  a_mal_held: assert property (@(posedge ref_clk) disable iff (!nrst)
    (malPending && !pswQ[swic_pkg::BIT_MAL]) |=> malPending)
    else $error("masked malfunction lost");
  a_mal_code: assert property (@(posedge ref_clk) disable iff (!nrst)
    takeMal |=> pswQ[swic_pkg::CC_LO:swic_pkg::CC_HI] == $past(malQCode))
    else $error("malfunction cause not reported");
  a_arith_mask: assert property (@(posedge ref_clk) disable iff (!nrst)
    (arithFault && !pswQ[swic_pkg::BIT_ARITH]) |-> !takeArith)
    else $error("arithmetic fault taken while disabled");
  a_stop_single: assert property (@(posedge ref_clk) disable iff (!nrst)
    execStep |-> !runQ ##1 !execStep)
    else $error("step while running or longer than one cycle");
  a_stop_no_exec: assert property (@(posedge ref_clk) disable iff (!nrst)
    !runQ |-> !execEnable)
    else $error("executing while stopped");
  a_arith_loads: assert property (@(posedge ref_clk) disable iff (!nrst)
    takeArith |=> pswQ[swic_pkg::LOC_LO:swic_pkg::LOC_HI] == $past(locArithQ))
    else $error("arithmetic fault service address not loaded");
endmodule

/* File: testbench.sv */
// Self-checking bench for the status word and interrupt control block
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, memData, entry = 32'h0000_0000;
  logic pready, pslverr, irq, extReq, extAck, memReq, memAck, adcStart, execEnable, execStep;
  logic malEvent = 1'b0, arithFault = 1'b0, raise = 1'b0;
  logic [3:0] malCode = 4'h0;
  logic [1:0] extLevel, level = 2'h0;
  logic [9:0] extDevice, device = 10'h000;
  logic [2:0] delay = 3'h0;
  logic [23:0] memAddr, adcCcbPtr;
  logic [63:0] pswOut;
  int num_errors = 0, cmp_count = 0;
  always #2 ref_clk = ~ref_clk;
  swic_status_ctrl u_dut (.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .extReq(extReq), .extLevel(extLevel),
    .extDevice(extDevice), .extAck(extAck), .malEvent(malEvent), .malCode(malCode),
    .arithFault(arithFault), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
    .memData(memData), .adcStart(adcStart), .adcCcbPtr(adcCcbPtr),
    .seqLocValid(1'b0), .seqLoc(24'h00_0000), .execEnable(execEnable),
    .execStep(execStep), .pswOut(pswOut));
  swic_dev_model u_dev (.ref_clk(ref_clk), .nrst(nrst), .raise(raise), .level(level),
    .device(device), .entry(entry), .delay(delay), .extReq(extReq), .extLevel(extLevel),
    .extDevice(extDevice), .extAck(extAck), .memReq(memReq), .memAck(memAck),
    .memData(memData));
  task automatic end_sim();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask
  // Bounded wait on a level; running out of cycles ends the run
  task automatic waitSig(ref logic s, input logic v, input string nm);
    int n;
    n = 0;
    while (s !== v && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (s !== v) begin
      chk(nm, 64'(v), 64'(s));
      end_sim();
    end
  endtask
  // One idle edge, setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic expErr, input logic [31:0] expRd);
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    waitSig(pready, 1'b1, "pready");
    chk("pslverr", 64'(expErr), 64'(pslverr));
    if (!w) chk("prdata", 64'(expRd), 64'(prdata));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] hb(input int b);
    return 32'h8000_0000 >> b;
  endfunction
  task automatic setPsw(input logic [31:0] hi);
    apb(1'b1, swic_pkg::OFF_CTRL, 32'h0000_0002, 1'b0, 32'h0);
    apb(1'b1, swic_pkg::OFF_PSW_HI, hi, 1'b0, 32'h0);
    apb(1'b1, swic_pkg::OFF_CTRL, 32'h0000_0001, 1'b0, 32'h0);
    // Run lands on the last edge; its enables are seen one edge later
    @(posedge ref_clk);
  endtask
  task automatic ext(input logic [9:0] dv, input logic [1:0] lv, input logic [31:0] en);
    @(posedge ref_clk);
    raise <= 1'b1;
    device <= dv;
    level <= lv;
    entry <= en;
    delay <= delay + 3'h2;
    @(posedge ref_clk);
    raise <= 1'b0;
  endtask
  task automatic t_basic();
    chk("psw reset", 64'h0, pswOut);
    chk("exec reset", 64'h0, 64'(execEnable));
    apb(1'b0, 12'h0f0, 32'h0, 1'b1, 32'h0);
    apb(1'b1, swic_pkg::OFF_STAT, 32'h0000_000f, 1'b1, 32'h0);
  endtask
  task automatic t_even();
    apb(1'b1, swic_pkg::OFF_TABLE, 32'h0000_1000, 1'b0, 32'h0);
    apb(1'b1, swic_pkg::OFF_NEW_EXT, hb(17), 1'b0, 32'h0);
    apb(1'b1, swic_pkg::OFF_MASK, 32'h0000_0001, 1'b0, 32'h0);
    setPsw(hb(17));
    chk("exec run", 64'h1, 64'(execEnable));
    apb(1'b1, swic_pkg::OFF_PSW_HI, 32'h0, 1'b1, 32'h0);
    ext(10'h005, 2'h2, 32'h0000_0200);
    waitSig(memReq, 1'b1, "memReq");
    chk("extAck", 64'h1, 64'(extAck));
    chk("memAddr", 64'h1014, 64'(memAddr));
    waitSig(memReq, 1'b0, "memReq");
    @(posedge ref_clk);
    chk("loc even", 64'h200, 64'(pswOut[23:0]));
    chk("irq set", 64'h1, 64'(irq));
    apb(1'b0, swic_pkg::OFF_OLD_HI, 32'h0, 1'b0, hb(17));
    apb(1'b0, swic_pkg::OFF_STAT, 32'h0, 1'b0, 32'h0000_0001);
    apb(1'b0, swic_pkg::OFF_STAT, 32'h0, 1'b0, 32'h0000_0000);
    chk("irq clear", 64'h0, 64'(irq));
  endtask
  task automatic t_odd();
    ext(10'h3ff, 2'h0, 32'h0000_0301);
    waitSig(adcStart, 1'b1, "adcStart");
    chk("adc ptr", 64'h301, 64'(adcCcbPtr));
    chk("loc odd", 64'h200, 64'(pswOut[23:0]));
    apb(1'b0, swic_pkg::OFF_STAT, 32'h0, 1'b0, 32'h0000_0009);
  endtask
  task automatic t_gate();
    int n;
    // Only higher levels than level 0 enabled: none may be taken
    setPsw(hb(20));
    ext(10'h001, 2'h0, 32'h0000_0400);
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      chk("gated ack", 64'h0, 64'(extAck));
    end
    chk("req held", 64'h1, 64'(extReq));
    setPsw(hb(17) | hb(20));
    waitSig(memReq, 1'b1, "memReq");
    waitSig(memReq, 1'b0, "memReq");
    @(posedge ref_clk);
    chk("loc gate", 64'h400, 64'(pswOut[23:0]));
    apb(1'b0, swic_pkg::OFF_STAT, 32'h0, 1'b0, 32'h0000_0001);
  endtask
  task automatic t_mal();
    apb(1'b1, swic_pkg::OFF_NEW_MAL, hb(17), 1'b0, 32'h0);
    apb(1'b1, swic_pkg::OFF_LOC_MAL, 32'h0000_0700, 1'b0, 32'h0);
    @(posedge ref_clk);
    malEvent <= 1'b1;
    malCode <= 4'hc;
    @(posedge ref_clk);
    malEvent <= 1'b0;
    apb(1'b0, swic_pkg::OFF_STATE, 32'h0, 1'b0, 32'h0000_0240);
    setPsw(hb(17) | hb(18));
    apb(1'b0, swic_pkg::OFF_STAT, 32'h0, 1'b0, 32'h0000_0002);
    chk("mal status", 64'h0000_400c, 64'(pswOut[63:32]));
    chk("mal loc", 64'h700, 64'(pswOut[23:0]));
  endtask
  task automatic t_arith();
    apb(1'b1, swic_pkg::OFF_NEW_ARITH, hb(17), 1'b0, 32'h0);
    apb(1'b1, swic_pkg::OFF_LOC_ARITH, 32'h0000_0500, 1'b0, 32'h0);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) setPsw(hb(17) | hb(19));
      @(posedge ref_clk);
      arithFault <= 1'b1;
      @(posedge ref_clk);
      arithFault <= 1'b0;
      apb(1'b0, swic_pkg::OFF_STAT, 32'h0, 1'b0, 32'(k * 4));
    end
    chk("arith loc", 64'h500, 64'(pswOut[23:0]));
  endtask
  task automatic t_wait();
    setPsw(hb(16) | hb(17));
    chk("wait stop", 64'h0, 64'(execEnable));
    ext(10'h002, 2'h1, 32'h0000_0600);
    waitSig(memReq, 1'b1, "memReq");
    waitSig(memReq, 1'b0, "memReq");
    @(posedge ref_clk);
    chk("wait left", 64'h1, 64'(execEnable));
    apb(1'b1, swic_pkg::OFF_CTRL, 32'h0000_0002, 1'b0, 32'h0);
    apb(1'b1, swic_pkg::OFF_CTRL, 32'h0000_0004, 1'b0, 32'h0);
    waitSig(execStep, 1'b1, "execStep");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_basic();
    t_even();
    t_odd();
    t_gate();
    t_mal();
    t_arith();
    t_wait();
    end_sim();
  end
endmodule
